// *** rtl/tsc_pkg.sv ***
// Constants and types for the timing and survey configuration message codec
// What this block does
// - Frames start 0x10, id 0x91, subpacket, 16-bit length of mode, data, checksum.
// - Frames end with checksum byte, then 0x10, then 0x03.
// - Survey query: subpacket 0x04, mode 0, length 2, checksum follows mode.
// - Timing response: subpacket 0x03, mode 2, length 0x0013, set-form byte order.
// - Time base bits 2:0 pick constellation 0..4; bit 3 selects its UTC.
// - Pulse reference byte encoded like time base, bit 3 selects UTC.
// - Pulse mask bits 2:0: off, always, with fix, when timing valid.
// - Pulse mask bit 3: 0 positive pulses, 1 negative pulses.
// - Pulse mask bit 4: 0 one pulse per second, 1 even two-second pulse.
// - Pulse mask bit 5 on oscillator variant only: frequency or phase steering.
// - Bytes 9-12 carry pulse rate on oscillator variant, else all ones.
// - Bytes 13-14 pulse width ms, MSB first; bytes 15-22 offset double.
// - Survey mask bit 0 set restarts the survey; clear is ignored.
// - Survey mask bit 1 enables the survey, clear disables it.
// - Survey mask bit 3 stores surveyed position when survey completes.
// - Configured fix count is averaged, then used for clock-only fixes.
// - Response restart bit reads 1 only after a restarting set.
package tsc_pkg;

  // ----------------------------------------
  // Framing bytes
  // ----------------------------------------
  localparam logic [7:0]  START_BYTE  = 8'h10;
  localparam logic [7:0]  PACKET_ID   = 8'h91;
  localparam logic [7:0]  SUB_TIMING  = 8'h03;
  localparam logic [7:0]  SUB_SURVEY  = 8'h04;
  localparam logic [7:0]  MODE_QUERY  = 8'h00;
  localparam logic [7:0]  MODE_SET    = 8'h01;
  localparam logic [7:0]  MODE_RESP   = 8'h02;
  localparam logic [7:0]  END_BYTE1   = 8'h10;
  localparam logic [7:0]  END_BYTE2   = 8'h03;
  localparam logic [15:0] LEN_QUERY   = 16'h0002;
  localparam logic [15:0] LEN_SURVEY  = 16'h000B;
  localparam logic [15:0] LEN_TIMING  = 16'h0013;

  // ----------------------------------------
  // Byte positions
  // ----------------------------------------
  localparam logic [3:0] BODY_LAST_QUERY  = 4'h0;
  localparam logic [3:0] BODY_LAST_SET    = 4'h9;
  localparam logic [4:0] POS_DATA         = 5'h06;
  localparam logic [4:0] POS_CSUM_SURVEY  = 5'h0F;
  localparam logic [4:0] POS_CSUM_TIMING  = 5'h17;
  localparam logic [4:0] POS_LAST_SURVEY  = 5'h11;
  localparam logic [4:0] POS_LAST_TIMING  = 5'h19;

  // ----------------------------------------
  // Field bits
  // ----------------------------------------
  localparam int BIT_UTC      = 3;
  localparam int BIT_POLARITY = 3;
  localparam int BIT_CADENCE  = 4;
  localparam int BIT_STEER    = 5;
  localparam int BIT_RESTART  = 0;
  localparam int BIT_ENABLE   = 1;
  localparam int BIT_SAVE     = 3;

  // ----------------------------------------
  // Limits and reset values
  // ----------------------------------------
  localparam logic [31:0] FIX_DEFAULT  = 32'h0000_07D0;
  localparam logic [31:0] FIX_MIN      = 32'h0000_0001;
  localparam logic [31:0] FIX_MAX      = 32'h0002_A300;
  localparam logic [15:0] UNC_DEFAULT  = 16'h0028;
  localparam logic [15:0] UNC_MIN      = 16'h0003;
  localparam logic [15:0] UNC_MAX      = 16'h03E8;
  localparam logic [31:0] RATE_NONE    = 32'hFFFF_FFFF;

  typedef enum logic [3:0] {
    RX_IDLE, RX_PID, RX_SUB, RX_LENH, RX_LENL, RX_BODY, RX_CSUM, RX_END1, RX_END2
  } tsc_rx_state_t;

endpackage

// *** rtl/tsc_xor_acc.sv ***
// Running XOR checksum over a byte stream
`timescale 1ns/1ps
module tsc_xor_acc (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Control
  input  wire logic       clear,
  input  wire logic       enable,
  input  wire logic [7:0] data,
  // Result
  output logic      [7:0] acc
);

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || clear) begin
      acc <= 8'h00;
    end else if (enable) begin
      acc <= acc ^ data;
    end
  end

endmodule

// *** rtl/tsc_range_chk.sv ***
// Inclusive range check of an unsigned field
`timescale 1ns/1ps
module tsc_range_chk #(
  parameter int           W  = 16,
  parameter logic [W-1:0] LO = '0,
  parameter logic [W-1:0] HI = '1
) (
  // Field under test
  input  wire logic [W-1:0] value,
  // Verdict
  output wire logic         ok
);

  if (LO > HI) begin : g_chk
    $error("tsc_range_chk: LO above HI");
  end

  assign ok = (value >= LO) && (value <= HI);

endmodule

// *** rtl/tsc_codec.sv ***
// Frame parser, survey configuration store and response sender
`timescale 1ns/1ps
module tsc_codec #(
  parameter int BODY_BYTES = 10
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Received bytes from the serial link
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  // Bytes to the serial link
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  input  wire logic        tx_ready,
  // Timing output configuration held elsewhere
  input  wire logic [7:0]  time_base_cfg,
  input  wire logic [7:0]  pulse_time_reference,
  input  wire logic [7:0]  pulse_output_control,
  input  wire logic [31:0] pulse_rate_hz,
  input  wire logic [15:0] pulse_width_ms,
  input  wire logic [63:0] pulse_offset_s,
  input  wire logic        osc_variant,
  // Decoded timing controls
  output logic      [2:0]  time_constellation,
  output logic             time_utc,
  output logic      [2:0]  pulse_ref_constellation,
  output logic             pulse_ref_utc,
  output logic      [2:0]  pulse_condition,
  output logic             pulse_negative,
  output logic             even_two_second_pulse,
  output logic             phase_steer,
  // Position fixes from the navigation engine
  input  wire logic        fix_valid,
  // Survey configuration and state
  output logic             survey_enable,
  output logic             save_position,
  output logic      [31:0] survey_fix_count,
  output logic      [15:0] horiz_uncertainty,
  output logic      [15:0] vert_uncertainty,
  output logic             survey_restart,
  output logic             survey_active,
  output logic      [31:0] survey_fix_tally,
  output logic             overdetermined_mode,
  output logic             position_stored,
  // Frame status pulses
  output logic             frame_error,
  output logic             set_rejected
);

  if (BODY_BYTES < 10) begin : g_chk
    $error("tsc_codec: BODY_BYTES must hold mode and nine data bytes");
  end

  // ----------------------------------------
  // Receive state
  // ----------------------------------------
  tsc_pkg::tsc_rx_state_t state;
  tsc_pkg::tsc_rx_state_t next_state;
  logic [7:0]  sub_id;
  logic [7:0]  len_hi;
  logic [3:0]  body_last;
  logic [3:0]  body_cnt;
  logic [7:0]  body [BODY_BYTES];
  logic        csum_ok;
  logic [7:0]  rx_acc;

  wire  [15:0] len_word   = {len_hi, rx_data};
  wire         len_query  = (len_word == tsc_pkg::LEN_QUERY);
  wire         len_set    = (len_word == tsc_pkg::LEN_SURVEY) && (sub_id == tsc_pkg::SUB_SURVEY);
  wire         len_ok     = len_query || len_set;
  wire         rx_sum_en  = rx_valid && (state inside {tsc_pkg::RX_PID, tsc_pkg::RX_SUB, tsc_pkg::RX_LENH,
                                                       tsc_pkg::RX_LENL, tsc_pkg::RX_BODY});
  wire         rx_end     = rx_valid && (state == tsc_pkg::RX_END2);
  wire         frame_done = rx_end && (rx_data == tsc_pkg::END_BYTE2) && csum_ok;
  wire         frame_bad  = rx_end && (rx_data == tsc_pkg::END_BYTE2) && !csum_ok;

  // Plain framing with no byte stuffing: a 0x10 inside data is taken literally
  always_comb begin
    next_state = state;
    if (rx_valid) begin
      case (state)
        tsc_pkg::RX_IDLE: begin
          if (rx_data == tsc_pkg::START_BYTE) next_state = tsc_pkg::RX_PID;
        end
        tsc_pkg::RX_PID: begin
          next_state = (rx_data == tsc_pkg::PACKET_ID) ? tsc_pkg::RX_SUB : tsc_pkg::RX_IDLE;
        end
        tsc_pkg::RX_SUB:  next_state = tsc_pkg::RX_LENH;
        tsc_pkg::RX_LENH: next_state = tsc_pkg::RX_LENL;
        tsc_pkg::RX_LENL: begin
          next_state = len_ok ? tsc_pkg::RX_BODY : tsc_pkg::RX_IDLE;
        end
        tsc_pkg::RX_BODY: begin
          if (body_cnt == body_last) next_state = tsc_pkg::RX_CSUM;
        end
        tsc_pkg::RX_CSUM: next_state = tsc_pkg::RX_END1;
        tsc_pkg::RX_END1: begin
          next_state = (rx_data == tsc_pkg::END_BYTE1) ? tsc_pkg::RX_END2 : tsc_pkg::RX_IDLE;
        end
        tsc_pkg::RX_END2: next_state = tsc_pkg::RX_IDLE;
        default:          next_state = tsc_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= tsc_pkg::RX_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sub_id    <= 8'h00;
      len_hi    <= 8'h00;
      body_last <= 4'h0;
      body_cnt  <= 4'h0;
      csum_ok   <= 1'b0;
    end else if (rx_valid) begin
      if (state == tsc_pkg::RX_SUB) sub_id <= rx_data;
      if (state == tsc_pkg::RX_LENH) len_hi <= rx_data;
      if (state == tsc_pkg::RX_LENL) body_last <= 4'(rx_data - 8'h02);
      body_cnt <= (state == tsc_pkg::RX_BODY) ? body_cnt + 4'h1 : 4'h0;
      if (state == tsc_pkg::RX_CSUM) csum_ok <= (rx_data == rx_acc);
    end
  end

  always_ff @(posedge clk) begin
    if (rx_valid && state == tsc_pkg::RX_BODY) body[body_cnt] <= rx_data;
  end

  // XOR from packet id through the last data byte
  tsc_xor_acc u_rx_sum (
    .clk    (clk),
    .resetn (resetn),
    .clear  (state == tsc_pkg::RX_IDLE),
    .enable (rx_sum_en),
    .data   (rx_data),
    .acc    (rx_acc)
  );

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  wire        mode_query = (body[0] == tsc_pkg::MODE_QUERY) && (body_last == tsc_pkg::BODY_LAST_QUERY);
  wire        mode_set   = (body[0] == tsc_pkg::MODE_SET) && (body_last == tsc_pkg::BODY_LAST_SET);
  wire        is_s_query = (sub_id == tsc_pkg::SUB_SURVEY) && mode_query;
  wire        is_s_set   = (sub_id == tsc_pkg::SUB_SURVEY) && mode_set;
  wire        is_t_query = (sub_id == tsc_pkg::SUB_TIMING) && mode_query;
  wire [7:0]  set_mask   = body[1];
  wire [31:0] set_fixes  = {body[2], body[3], body[4], body[5]};
  wire [15:0] set_horiz  = {body[6], body[7]};
  wire [15:0] set_vert   = {body[8], body[9]};
  wire        fix_ok;
  wire        horiz_ok;
  wire        vert_ok;
  wire        set_ok     = fix_ok && horiz_ok && vert_ok;
  wire        apply      = frame_done && is_s_set && set_ok;
  wire        restart    = apply && set_mask[tsc_pkg::BIT_RESTART];

  tsc_range_chk #(.W(32), .LO(tsc_pkg::FIX_MIN), .HI(tsc_pkg::FIX_MAX)) u_fix_chk (
    .value (set_fixes),
    .ok    (fix_ok)
  );

  tsc_range_chk #(.W(16), .LO(tsc_pkg::UNC_MIN), .HI(tsc_pkg::UNC_MAX)) u_horiz_chk (
    .value (set_horiz),
    .ok    (horiz_ok)
  );

  tsc_range_chk #(.W(16), .LO(tsc_pkg::UNC_MIN), .HI(tsc_pkg::UNC_MAX)) u_vert_chk (
    .value (set_vert),
    .ok    (vert_ok)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      frame_error  <= 1'b0;
      set_rejected <= 1'b0;
    end else begin
      frame_error  <= frame_bad;
      set_rejected <= frame_done && is_s_set && !set_ok;
    end
  end

  // ----------------------------------------
  // Survey configuration store
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      survey_enable     <= 1'b1;
      save_position     <= 1'b0;
      survey_fix_count  <= tsc_pkg::FIX_DEFAULT;
      horiz_uncertainty <= tsc_pkg::UNC_DEFAULT;
      vert_uncertainty  <= tsc_pkg::UNC_DEFAULT;
      survey_restart    <= 1'b0;
    end else begin
      survey_restart <= restart;
      if (apply) begin
        survey_enable     <= set_mask[tsc_pkg::BIT_ENABLE];
        save_position     <= set_mask[tsc_pkg::BIT_SAVE];
        survey_fix_count  <= set_fixes;
        horiz_uncertainty <= set_horiz;
        vert_uncertainty  <= set_vert;
      end
    end
  end

  // ----------------------------------------
  // Survey progress
  // ----------------------------------------
  // Averaging itself lives in the navigation engine; this tracks the fix count
  wire survey_last = (survey_fix_tally + 32'h1) >= survey_fix_count;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      survey_active       <= 1'b1;
      survey_fix_tally    <= 32'h0;
      overdetermined_mode <= 1'b0;
      position_stored     <= 1'b0;
    end else if (restart) begin
      survey_active       <= set_mask[tsc_pkg::BIT_ENABLE];
      survey_fix_tally    <= 32'h0;
      overdetermined_mode <= 1'b0;
      position_stored     <= 1'b0;
    end else if (apply && !set_mask[tsc_pkg::BIT_ENABLE]) begin
      survey_active <= 1'b0;
    end else if (survey_active && fix_valid) begin
      survey_fix_tally <= survey_fix_tally + 32'h1;
      if (survey_last) begin
        survey_active       <= 1'b0;
        overdetermined_mode <= 1'b1;
        position_stored     <= save_position;
      end
    end
  end

  // ----------------------------------------
  // Timing control decode
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      time_constellation      <= 3'h0;
      time_utc                <= 1'b0;
      pulse_ref_constellation <= 3'h0;
      pulse_ref_utc           <= 1'b0;
      pulse_condition         <= 3'h0;
      pulse_negative          <= 1'b0;
      even_two_second_pulse   <= 1'b0;
      phase_steer             <= 1'b0;
    end else begin
      time_constellation      <= time_base_cfg[2:0];
      time_utc                <= time_base_cfg[tsc_pkg::BIT_UTC];
      pulse_ref_constellation <= pulse_time_reference[2:0];
      pulse_ref_utc           <= pulse_time_reference[tsc_pkg::BIT_UTC];
      pulse_condition         <= pulse_output_control[2:0];
      pulse_negative          <= pulse_output_control[tsc_pkg::BIT_POLARITY];
      even_two_second_pulse   <= pulse_output_control[tsc_pkg::BIT_CADENCE];
      phase_steer             <= osc_variant && pulse_output_control[tsc_pkg::BIT_STEER];
    end
  end

  // ----------------------------------------
  // Pending responses
  // ----------------------------------------
  // One of each kind may wait; a repeat before sending merges into it
  logic pend_survey;
  logic pend_timing;
  logic pend_restart;
  wire  tx_start   = !tx_valid && (pend_survey || pend_timing);
  wire  take_surv  = tx_start && pend_survey;
  wire  take_time  = tx_start && !pend_survey;
  wire  req_survey = frame_done && (is_s_query || is_s_set);
  wire  req_timing = frame_done && is_t_query;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pend_survey  <= 1'b0;
      pend_timing  <= 1'b0;
      pend_restart <= 1'b0;
    end else begin
      pend_survey  <= (pend_survey && !take_surv) || req_survey;
      pend_timing  <= (pend_timing && !take_time) || req_timing;
      pend_restart <= (pend_restart && !take_surv) || restart;
    end
  end

  // ----------------------------------------
  // Response payload
  // ----------------------------------------
  wire [7:0]   resp_smask  = {4'h0, save_position, 1'b0, survey_enable, pend_restart};
  wire [7:0]   resp_pmask  = osc_variant ? pulse_output_control
                                         : (pulse_output_control & ~(8'h01 << tsc_pkg::BIT_STEER));
  wire [31:0]  resp_rate   = osc_variant ? pulse_rate_hz : tsc_pkg::RATE_NONE;
  wire [135:0] snap_survey = {resp_smask, survey_fix_count, horiz_uncertainty, vert_uncertainty, 64'h0};
  wire [135:0] snap_timing = {time_base_cfg, pulse_time_reference, resp_pmask, resp_rate,
                              pulse_width_ms, pulse_offset_s};

  // ----------------------------------------
  // Transmit sequencer
  // ----------------------------------------
  logic [135:0] tx_snap;
  logic         tx_timing;
  logic [4:0]   tx_idx;
  logic [7:0]   tx_acc;

  wire         tx_take   = tx_valid && tx_ready;
  wire [4:0]   csum_pos  = tx_timing ? tsc_pkg::POS_CSUM_TIMING : tsc_pkg::POS_CSUM_SURVEY;
  wire [4:0]   last_pos  = tx_timing ? tsc_pkg::POS_LAST_TIMING : tsc_pkg::POS_LAST_SURVEY;
  wire [15:0]  tx_len    = tx_timing ? tsc_pkg::LEN_TIMING : tsc_pkg::LEN_SURVEY;
  wire [7:0]   tx_sub    = tx_timing ? tsc_pkg::SUB_TIMING : tsc_pkg::SUB_SURVEY;
  wire [4:0]   data_off  = tx_idx - tsc_pkg::POS_DATA;
  wire [135:0] snap_sh   = tx_snap << {data_off, 3'b000};
  wire [7:0]   data_byte = snap_sh[135:128];
  wire         tx_sum_en = tx_take && (tx_idx >= 5'h02) && (tx_idx <= csum_pos);
  wire [7:0]   tx_byte   = (tx_idx == 5'h01) ? tsc_pkg::PACKET_ID :
                           (tx_idx == 5'h02) ? tx_sub :
                           (tx_idx == 5'h03) ? tx_len[15:8] :
                           (tx_idx == 5'h04) ? tx_len[7:0] :
                           (tx_idx == 5'h05) ? tsc_pkg::MODE_RESP :
                           (tx_idx <  csum_pos) ? data_byte :
                           (tx_idx == csum_pos) ? (tx_acc ^ tx_data) :
                           (tx_idx == csum_pos + 5'h01) ? tsc_pkg::END_BYTE1 :
                           tsc_pkg::END_BYTE2;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_valid  <= 1'b0;
      tx_data   <= 8'h00;
      tx_idx    <= 5'h00;
      tx_timing <= 1'b0;
      tx_snap   <= 136'h0;
    end else if (tx_start) begin
      tx_valid  <= 1'b1;
      tx_data   <= tsc_pkg::START_BYTE;
      tx_idx    <= 5'h01;
      tx_timing <= !pend_survey;
      tx_snap   <= pend_survey ? snap_survey : snap_timing;
    end else if (tx_take) begin
      if (tx_idx > last_pos) begin
        tx_valid <= 1'b0;
      end else begin
        tx_data <= tx_byte;
        tx_idx  <= tx_idx + 5'h01;
      end
    end
  end

  tsc_xor_acc u_tx_sum (
    .clk    (clk),
    .resetn (resetn),
    .clear  (tx_start),
    .enable (tx_sum_en),
    .data   (tx_data),
    .acc    (tx_acc)
  );

endmodule

// *** verification/tsc_host.sv ***
// Host controller model: frame sender and response sink
`timescale 1ns/1ps
module tsc_host (
  // Clock
  input  wire logic       clk,
  // Sink pacing
  input  wire logic       slow,
  // Link to the codec
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_data
);
  logic [7:0] q[$];
  logic [7:0] rq[$];
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b1;
  end
  // Idle data toggles so a stale byte never looks valid
  always @(negedge clk) begin
    if (q.size() != 0) begin
      rx_valid <= 1'b1;
      rx_data  <= q.pop_front();
    end else begin
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      rq.push_back(tx_data);
    end
  end
endmodule

// *** verification/tsc_checker.sv ***
// Port-level assertions for the codec
`timescale 1ns/1ps
module tsc_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Observed ports
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [7:0]  tx_data,
  input wire logic [7:0]  time_base_cfg,
  input wire logic [7:0]  pulse_output_control,
  input wire logic        osc_variant,
  input wire logic [2:0]  time_constellation,
  input wire logic        time_utc,
  input wire logic [2:0]  pulse_condition,
  input wire logic        pulse_negative,
  input wire logic        even_two_second_pulse,
  input wire logic        phase_steer,
  input wire logic [31:0] survey_fix_count,
  input wire logic [15:0] horiz_uncertainty,
  input wire logic [15:0] vert_uncertainty,
  input wire logic        survey_restart,
  input wire logic        overdetermined_mode,
  input wire logic        position_stored,
  input wire logic        frame_error,
  input wire logic        set_rejected
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_stall; tx_valid && !tx_ready; endsequence
  sequence s_held; tx_valid && $stable(tx_data); endsequence
  a_tx_hold: assert property (s_stall |=> s_held)
    else $error("tx byte changed before take");
  a_frame_start: assert property ($rose(tx_valid) |-> tx_data == 8'h10)
    else $error("response not opened by start byte");
  a_time_decode: assert property ($past(resetn) |-> time_constellation == $past(time_base_cfg[2:0])
    && time_utc == $past(time_base_cfg[3])) else $error("time base decode wrong");
  a_pulse_decode: assert property ($past(resetn) |-> pulse_condition == $past(pulse_output_control[2:0])
    && pulse_negative == $past(pulse_output_control[3])
    && even_two_second_pulse == $past(pulse_output_control[4])) else $error("pulse mask decode wrong");
  a_steer_gate: assert property ($past(resetn) |->
    phase_steer == ($past(osc_variant) && $past(pulse_output_control[5]))) else $error("steer not gated");
  a_reject_keeps: assert property (set_rejected |-> $stable(survey_fix_count) && !survey_restart
    && $stable(horiz_uncertainty) && $stable(vert_uncertainty)) else $error("rejected set changed config");
  a_error_keeps: assert property (frame_error |-> $stable(survey_fix_count) && !set_rejected
    && !survey_restart) else $error("bad frame had an effect");
  a_fix_range: assert property (survey_fix_count >= 32'h1 && survey_fix_count <= 32'h2A300)
    else $error("fix count out of range");
  a_unc_range: assert property (horiz_uncertainty >= 16'h3 && horiz_uncertainty <= 16'h3E8
    && vert_uncertainty >= 16'h3 && vert_uncertainty <= 16'h3E8) else $error("uncertainty out of range");
  a_store_done: assert property ($rose(position_stored) |-> overdetermined_mode)
    else $error("position stored before survey done");
endmodule

// *** verification/timing_survey_config_codec_test.sv ***
// Self-checking bench for the codec
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module timing_survey_config_codec_test;
  logic        clk, resetn, rx_valid, tx_valid, tx_ready, osc_variant, fix_valid, slow;
  logic [7:0]  rx_data, tx_data, time_base_cfg, pulse_time_reference, pulse_output_control;
  logic [31:0] pulse_rate_hz, survey_fix_count, survey_fix_tally;
  logic [15:0] pulse_width_ms, horiz_uncertainty, vert_uncertainty;
  logic [63:0] pulse_offset_s;
  logic [2:0]  time_constellation, pulse_ref_constellation, pulse_condition, seen;
  logic        time_utc, pulse_ref_utc, pulse_negative, even_two_second_pulse, phase_steer;
  logic        survey_enable, save_position, survey_restart, survey_active, overdetermined_mode;
  logic        position_stored, frame_error, set_rejected;
  logic [7:0]  bq[$], fq[$];
  int          miscompares, comparisons;

  tsc_codec i_dut (.clk, .resetn, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready, .time_base_cfg,
    .pulse_time_reference, .pulse_output_control, .pulse_rate_hz, .pulse_width_ms, .pulse_offset_s,
    .osc_variant, .time_constellation, .time_utc, .pulse_ref_constellation, .pulse_ref_utc, .pulse_condition,
    .pulse_negative, .even_two_second_pulse, .phase_steer, .fix_valid, .survey_enable, .save_position,
    .survey_fix_count, .horiz_uncertainty, .vert_uncertainty, .survey_restart, .survey_active,
    .survey_fix_tally, .overdetermined_mode, .position_stored, .frame_error, .set_rejected);
  tsc_host i_host (.clk, .slow, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Pulses last one cycle, so they are latched here
  always @(posedge clk) seen <= seen | {survey_restart, set_rejected, frame_error};

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task b(input logic [167:0] v, input int n);
    bq.delete();
    for (int i = n - 1; i >= 0; i--) bq.push_back(v[8*i +: 8]);
  endtask
  task frm;
    logic [7:0] c;
    c = 8'h91;
    foreach (bq[i]) c ^= bq[i];
    fq = {8'h10, 8'h91, bq, c, 8'h10, 8'h03};
  endtask
  task send(input logic bad);
    frm;
    if (bad) fq[6] = ~fq[6];
    seen = 3'h0;
    foreach (fq[i]) i_host.q.push_back(fq[i]);
    cyc(fq.size() + 4);
  endtask
  task expect_rx;
    int k;
    frm;
    for (k = 0; k < 2000 && i_host.rq.size() < fq.size(); k++) cyc(1);
    if (k == 2000) begin
      miscompares++;
      conclude;
    end
    foreach (fq[i]) `CHK(i_host.rq[i], fq[i])
    i_host.rq.delete();
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    slow = 1'b0;
    fix_valid = 1'b0;
    osc_variant = 1'b0;
    time_base_cfg = 8'h00;
    pulse_time_reference = 8'h00;
    pulse_output_control = 8'h00;
    pulse_rate_hz = 32'h0098_9680;
    pulse_width_ms = 16'h00C8;
    pulse_offset_s = 64'h0102_0304_0506_0708;
    seen = 3'h0;
    miscompares = 0;
    comparisons = 0;
    cyc(12);
    resetn = 1'b1;
    cyc(1);
    `CHK(survey_fix_count, 32'h0000_07D0)
    `CHK({horiz_uncertainty, vert_uncertainty}, 32'h0028_0028)
    `CHK({survey_enable, save_position}, 2'h2)
    for (int i = 0; i < 64; i++) begin
      time_base_cfg = i[7:0];
      pulse_output_control = i[7:0];
      osc_variant = i[0];
      cyc(1);
    end
    done("defaults");
    b(32'h0400_0200, 4);
    send(1'b0);
    b(104'h04000B0202000007D000280028, 13);
    expect_rx;
    slow = 1'b1;
    b(104'h04000B010A000000C800280028, 13);
    send(1'b0);
    `CHK(seen, 3'h0)
    `CHK({survey_fix_count, save_position, survey_enable}, {32'h0000_00C8, 2'h3})
    bq[3] = 8'h02;
    expect_rx;
    slow = 1'b0;
    done("set");
    b(104'h04000B010B00000003000303E8, 13);
    send(1'b0);
    `CHK(seen, 3'h4)
    bq[3] = 8'h02;
    expect_rx;
    repeat (3) begin
      fix_valid = 1'b1;
      cyc(1);
      fix_valid = 1'b0;
      cyc(1);
    end
    for (int k = 0; k < 20 && overdetermined_mode !== 1'b1; k++) cyc(1);
    `CHK({overdetermined_mode, position_stored}, 2'h3)
    `CHK({survey_active, survey_fix_tally}, {1'b0, 32'h0000_0003})
    done("restart");
    b(104'h04000B01020002A30100280028, 13);
    send(1'b0);
    `CHK(seen, 3'h2)
    b(104'h04000B020A00000003000303E8, 13);
    expect_rx;
    b(32'h0400_0200, 4);
    send(1'b1);
    cyc(20);
    `CHK(seen, 3'h1)
    `CHK(i_host.rq.size(), 0)
    done("refusals");
    time_base_cfg = 8'h0C;
    pulse_time_reference = 8'h09;
    pulse_output_control = 8'h3A;
    for (int o = 0; o < 2; o++) begin
      osc_variant = o[0];
      b(32'h0300_0200, 4);
      send(1'b0);
      `CHK({time_utc, time_constellation, pulse_ref_utc, pulse_ref_constellation}, 8'hC9)
      `CHK({pulse_negative, even_two_second_pulse, pulse_condition}, 5'h1A)
      `CHK(phase_steer, o[0])
      b(o ? 168'h030013020C093A0098968000C80102030405060708
          : 168'h030013020C091AFFFFFFFF00C80102030405060708, 21);
      expect_rx;
    end
    done("timing");
    conclude;
  end
endmodule

bind tsc_codec tsc_checker i_chk (.clk, .resetn, .tx_valid, .tx_ready, .tx_data, .time_base_cfg,
  .pulse_output_control, .osc_variant, .time_constellation, .time_utc, .pulse_condition, .pulse_negative,
  .even_two_second_pulse, .phase_steer, .survey_fix_count, .horiz_uncertainty, .vert_uncertainty,
  .survey_restart, .overdetermined_mode, .position_stored, .frame_error, .set_rejected);
